// [lcs_sequencer.v]
/*
  Lubrication cycle sequencer: standby and lubrication phases, cycle
  monitoring, timeout supervision, prelube and alarm stop policy.
  Assumes field inputs are asynchronous and settings are static levels
  from the same clock. Retained phase and cycle progress come from and go to
  an external non-volatile store through plain ports.
*/
// What this block does
// - In cycle mode a cycle ends on the run timer, the cycle sensor or a pressure switch edge.
// - In pulse mode both phases end on external pulse counts, not timers.
// - Monitor is timer or pressure switch in cycle mode, none or switch in pulse.
// - Standby ends by timer, counter, or whichever first; default six minutes.
// - Counter-with-timeout standby ends on count, alarms if the timer expires first.
// - Each lube cycle except a timed run in cycle mode runs a timeout; expiry raises a timeout alarm.
// - Timer monitoring keeps the pump on for the set run time.
// - Count cycles and end lubrication at the set count, one to 250.
// - At power-on enter standby, lubrication or the retained phase.
// - Perform the set number of prelube cycles, zero to 250.
// - Standard style drops the alarm relay while an alarm exists.
// - Coded style pulses the relay with the alarm number.
// - Stop policy picks which alarms halt lubrication, including none.
// - Coded bursts are 500 ms with a 2000 ms gap before repeating.
// - Stop on every alarm, all but low level, or low level only.
`timescale 1ns/1ps
`include "lcs_defines.vh"

module lcs_sequencer #(
  parameter TICK_CYC = `LCS_TICK_CYC  // Cycles per 100 ms tick
) (
  input  wire        sys_clk,      // 10 MHz clock
  input  wire        rst_n,        // Synchronous reset, low
  input  wire        clkEn,        // Freezes all state when low
  input  wire        cycleEnd,     // Completion mode, 0 cycle 1 pulse
  input  wire [1:0]  cycleMonitor, // Monitor selection
  input  wire [1:0]  standby_source_select, // Standby source
  input  wire [19:0] standbySec,   // Standby time, seconds
  input  wire [7:0]  cycleToutSec, // Cycle timeout, seconds
  input  wire [7:0]  lubeSec,      // Pump run time, seconds
  input  wire [7:0]  lubeCycles,   // Cycles per phase
  input  wire [15:0] pauseCount,   // Standby pulse count
  input  wire [15:0] cycleCount,   // Lube pulse count, pulse mode
  input  wire [1:0]  powerOnMode,  // Power-on phase selection
  input  wire [7:0]  prelubeCount, // Prelube cycles
  input  wire        alarmCoded,   // Alarm style
  input  wire [1:0]  stopPolicy,   // Which alarms stop
  input  wire        alarmClear,   // Clears latched alarms
  input  wire        keptLube,     // Retained phase, 1 lubricating
  input  wire [7:0]  keptCycles,   // Retained cycle progress
  input  wire        cycleSensorIn, // Cycle sensor pin
  input  wire        pressureIn,   // Pressure switch pin
  input  wire        pulseIn,      // External pulse pin
  input  wire        lowLevelIn,   // Low level sensor pin
  output reg         pumpOn,       // Pump motor drive
  output reg         inLube,       // Lubrication phase active
  output reg         alarmRelay,   // Remote relay energised
  output reg  [3:0]  alarmCode,    // Active alarm number
  output reg         saveStrobe,   // Pulse: store phase and progress
  output reg  [7:0]  saveCycles    // Progress to retain
);

  localparam ST_BOOT = 3'h0;
  localparam ST_SBY  = 3'h1;
  localparam ST_RUN  = 3'h2;
  localparam ST_HOLD = 3'h3;
  localparam ST_STOP = 3'h4;
  localparam [31:0] TICK_LAST = TICK_CYC - 1;  // Wide so the divider takes a slice

  // Lubrication phase covers the run and the one-clock rest between cycles
  function isLube;
    input [2:0] st;
    isLube = (st == ST_RUN) || (st == ST_HOLD);
  endfunction

  reg [2:0]  state;
  reg [2:0]  next_state;
  reg [3:0]  syncA;
  reg [3:0]  syncB;
  reg [3:0]  prevB;
  reg [23:0] tickDiv;
  reg        tick;
  reg [3:0]  subSec;
  reg [19:0] secCnt;
  reg [15:0] pulseCnt;
  reg [7:0]  cycDone;
  reg [7:0]  preLeft;
  reg        almPause;
  reg        almPress;
  reg        stopIt;
  wire       codedRelay;

  // Field pins are asynchronous, so two flops before use
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      syncA <= 4'h0;
      syncB <= 4'h0;
      prevB <= 4'h0;
    end else if (clkEn) begin
      syncA <= {lowLevelIn, pulseIn, pressureIn, cycleSensorIn};
      syncB <= syncA;
      prevB <= syncB;
    end
  end

  wire sensorOk  = syncB[0] & ~prevB[0];
  wire pressOk   = syncB[1];
  wire pressRise = syncB[1] & ~prevB[1];
  wire pulseEdge = syncB[2] & ~prevB[2];
  wire lowLevel  = syncB[3];

  // 100 ms time base keeps second counters narrow
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      tickDiv <= 24'h000000;
      tick    <= 1'b0;
      subSec  <= 4'h0;
    end else if (clkEn) begin
      tick <= 1'b0;
      if (tickDiv >= TICK_LAST[23:0]) begin
        tickDiv <= 24'h000000;
        tick    <= 1'b1;
      end else begin
        tickDiv <= tickDiv + 24'h000001;
      end
      if (tick) begin
        subSec <= (subSec == 4'h9) ? 4'h0 : subSec + 4'h1;
      end
    end
  end

  wire secTick = tick & (subSec == 4'h9);

  // effective monitor, pulse mode has no timer choice
  wire [1:0] mon = (cycleEnd == `LCS_END_PULSE)
                   ? ((cycleMonitor == `LCS_MON_PS) ? `LCS_MON_PS : `LCS_MON_NONE)
                   : ((cycleMonitor == `LCS_MON_PS) ? `LCS_MON_PS : `LCS_MON_TIMER);

  wire sbyTimeUp = (secCnt >= standbySec);
  wire sbyCntUp  = (pulseCnt >= pauseCount);
  reg  sbyDone;
  always @* begin
    sbyDone = 1'b0;
    if (cycleEnd == `LCS_END_PULSE) begin
      sbyDone = sbyCntUp;
    end else begin
      case (standby_source_select)
        `LCS_SBY_TIMER:  sbyDone = sbyTimeUp;
        `LCS_SBY_COUNT:  sbyDone = sbyCntUp;
        `LCS_SBY_EITHER: sbyDone = sbyTimeUp | sbyCntUp;
        default:         sbyDone = sbyCntUp;
      endcase
    end
  end

  // Cycle completion per mode and monitor
  reg cycOk;
  always @* begin
    cycOk = 1'b0;
    if (cycleEnd == `LCS_END_PULSE) begin
      cycOk = (pulseCnt >= cycleCount) & ((mon != `LCS_MON_PS) | pressOk);
    end else if (mon == `LCS_MON_TIMER) begin
      cycOk = (secCnt >= {12'h000, lubeSec});
    end else begin
      // sensor or fresh switch edge; a level may linger from the last cycle
      cycOk = sensorOk | pressRise;
    end
  end

  // timeout does not apply to a plain timed run
  wire cycTout = (mon != `LCS_MON_TIMER || cycleEnd == `LCS_END_PULSE)
                 && (secCnt >= {12'h000, cycleToutSec});
  wire lastCyc = (preLeft != 8'h00) ? (preLeft == 8'h01)
                 : (cycDone + 8'h01 >= lubeCycles);

  always @* begin
    case (stopPolicy)
      `LCS_STOP_NONE:    stopIt = 1'b0;
      `LCS_STOP_ALL:     stopIt = lowLevel | almPause | almPress;
      `LCS_STOP_NOTLEV:  stopIt = almPause | almPress;
      `LCS_STOP_LEVONLY: stopIt = lowLevel;
      default:           stopIt = 1'b0;
    endcase
  end

  // a timeout halts the run only where the policy stops on it
  wire toutStops = (stopPolicy == `LCS_STOP_ALL) || (stopPolicy == `LCS_STOP_NOTLEV);
  wire cycFin    = cycOk | (cycTout & ~toutStops);
  wire countNow  = (state == ST_RUN) && cycFin && !stopIt;

  // progress after this edge, also the value offered for retention
  wire [7:0] next_cycDone = (state == ST_BOOT)
                            ? ((powerOnMode == `LCS_PON_RESUME) ? keptCycles : 8'h00)
                            : (countNow && preLeft == 8'h00)
                              ? (lastCyc ? 8'h00 : cycDone + 8'h01)
                              : cycDone;

  // Phase sequencing
  always @* begin
    next_state = state;
    case (state)
      ST_BOOT: begin
        if (powerOnMode == `LCS_PON_LUBE || prelubeCount != 8'h00)
          next_state = ST_RUN;
        else if (powerOnMode == `LCS_PON_RESUME && keptLube)
          next_state = ST_RUN;
        else
          next_state = ST_SBY;
      end
      ST_SBY:  next_state = stopIt ? ST_STOP : (sbyDone ? ST_RUN : ST_SBY);
      ST_RUN:  begin
        if (stopIt)
          next_state = ST_STOP;
        else if (cycFin)
          next_state = lastCyc ? ST_SBY : ST_HOLD;
        else if (cycTout)
          next_state = ST_STOP;
      end
      ST_HOLD: next_state = ST_RUN;
      ST_STOP: next_state = (alarmClear && !lowLevel) ? ST_SBY : ST_STOP;
      default: next_state = ST_SBY;
    endcase
  end

  // State, counters and latched alarms
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state      <= ST_BOOT;
      secCnt     <= 20'h00000;
      pulseCnt   <= 16'h0000;
      cycDone    <= 8'h00;
      preLeft    <= 8'h00;
      almPause   <= 1'b0;
      almPress   <= 1'b0;
      saveStrobe <= 1'b0;
      saveCycles <= 8'h00;
      pumpOn     <= 1'b0;
      inLube     <= 1'b0;
      alarmCode  <= 4'h0;
    end else if (clkEn) begin
      state      <= next_state;
      saveStrobe <= 1'b0;
      if (next_state != state) begin
        secCnt   <= 20'h00000;
        pulseCnt <= 16'h0000;
      end else begin
        if (secTick)
          secCnt <= secCnt + 20'h00001;
        if (pulseEdge && pulseCnt != 16'hFFFF)
          pulseCnt <= pulseCnt + 16'h0001;
      end
      cycDone <= next_cycDone;
      if (state == ST_BOOT) begin
        preLeft <= prelubeCount;
      end else if (countNow && preLeft != 8'h00) begin
        preLeft <= preLeft - 8'h01;
      end
      // pause timeout alarm, set wins over clear
      if (state == ST_SBY && cycleEnd == `LCS_END_CYCLE
          && standby_source_select == `LCS_SBY_TOUT && sbyTimeUp && !sbyCntUp)
        almPause <= 1'b1;
      else if (alarmClear)
        almPause <= 1'b0;
      if (state == ST_RUN && !cycOk && cycTout)
        almPress <= 1'b1;
      else if (alarmClear)
        almPress <= 1'b0;
      // retain on a change of phase, not on the rest between cycles
      if (isLube(next_state) != isLube(state) && state != ST_BOOT) begin
        saveStrobe <= 1'b1;
        saveCycles <= next_cycDone;
      end
      pumpOn    <= (next_state == ST_RUN);
      inLube    <= isLube(next_state);
      alarmCode <= lowLevel ? `LCS_ALARM_LEVEL
                 : almPress ? `LCS_ALARM_PRESS
                 : almPause ? `LCS_ALARM_PAUSE : 4'h0;
    end
  end

  // Relay coder registers its own output
  lcs_alarm_coder uCoder (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .tick       (tick),
    .codedStyle (alarmCoded),
    .alarmCode  (alarmCode),
    .relayOn    (codedRelay)
  );

  always @(posedge sys_clk) begin
    if (!rst_n)
      alarmRelay <= 1'b1;
    else if (clkEn)
      alarmRelay <= codedRelay;
  end

endmodule // lcs_sequencer

// [lcs_defines.vh]
/*
  Constants for the lubrication cycle sequencer: mode encodings,
  default settings and coded-alarm timing. Assumes a 10 MHz sys_clk.
*/
`ifndef LCS_DEFINES_VH
`define LCS_DEFINES_VH

`define LCS_CLK_HZ          10000000
`define LCS_TICK_MS         100
`define LCS_TICK_CYC        ((`LCS_CLK_HZ / 1000) * `LCS_TICK_MS)

// Completion mode
`define LCS_END_CYCLE       1'b0
`define LCS_END_PULSE       1'b1
// Cycle monitor: timer / no control / pressure switch
`define LCS_MON_TIMER       2'h0
`define LCS_MON_NONE        2'h1
`define LCS_MON_PS          2'h2
// Standby source
`define LCS_SBY_TIMER       2'h0
`define LCS_SBY_COUNT       2'h1
`define LCS_SBY_EITHER      2'h2
`define LCS_SBY_TOUT        2'h3
// Power-on phase
`define LCS_PON_STANDBY     2'h0
`define LCS_PON_LUBE        2'h1
`define LCS_PON_RESUME      2'h2
// Stop policy
`define LCS_STOP_NONE       2'h0
`define LCS_STOP_ALL        2'h1
`define LCS_STOP_NOTLEV     2'h2
`define LCS_STOP_LEVONLY    2'h3
// Alarm style
`define LCS_ALM_STD         1'b0
`define LCS_ALM_CODED       1'b1

// Defaults, standby in seconds, others in seconds or counts
`define LCS_DEF_STANDBY_S   20'h00168
`define LCS_DEF_TOUT_S      8'h1E
`define LCS_DEF_LUBE_S      8'h1E
`define LCS_DEF_CYCLES      8'h01
`define LCS_DEF_PRELUBE     8'h00

// Alarm codes
`define LCS_ALARM_LEVEL     4'h1
`define LCS_ALARM_PAUSE     4'h8
`define LCS_ALARM_PRESS     4'h7

// Coded-alarm timing
`define LCS_BURST_MS        500
`define LCS_GAP_MS          2000
`define LCS_BURST_TICKS     (`LCS_BURST_MS / `LCS_TICK_MS)
`define LCS_GAP_TICKS       (`LCS_GAP_MS / `LCS_TICK_MS)

`endif

// [lcs_alarm_coder.v]
/*
  Remote alarm relay driver, standard or pulse coded.
  Assumes a 100 ms tick pulse on the same clock.
*/
`timescale 1ns/1ps
`include "lcs_defines.vh"

module lcs_alarm_coder (
  input  wire       sys_clk,    // System clock
  input  wire       rst_n,      // Synchronous reset, low
  input  wire       clkEn,      // Clock enable
  input  wire       tick,       // 100 ms tick
  input  wire       codedStyle, // High for coded style
  input  wire [3:0] alarmCode,  // Active alarm, zero when none
  output reg        relayOn     // Relay energised
);

  reg [3:0] pulseLeft;
  reg [4:0] tickCnt;
  reg       inGap;

  // Last tick of gap and burst, kept wide so the compares take a slice
  localparam [31:0] GAP_LAST   = `LCS_GAP_TICKS - 1;
  localparam [31:0] BURST_LAST = `LCS_BURST_TICKS - 1;

  // Relay held energised when no alarm; standard style drops it for the alarm
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      relayOn   <= 1'b1;
      pulseLeft <= 4'h0;
      tickCnt   <= 5'h00;
      inGap     <= 1'b1;
    end else if (clkEn) begin
      if (alarmCode == 4'h0) begin
        relayOn   <= 1'b1;
        pulseLeft <= 4'h0;
        tickCnt   <= 5'h00;
        inGap     <= 1'b1;
      end else if (codedStyle != `LCS_ALM_CODED) begin
        relayOn <= 1'b0;
      end else if (tick) begin
        if (inGap) begin
          relayOn <= 1'b0;
          if (tickCnt >= GAP_LAST[4:0]) begin
            inGap     <= 1'b0;
            tickCnt   <= 5'h00;
            pulseLeft <= alarmCode;
            relayOn   <= 1'b1;
          end else begin
            tickCnt <= tickCnt + 5'h01;
          end
        end else if (tickCnt >= BURST_LAST[4:0]) begin
          tickCnt <= 5'h00;
          if (relayOn) begin
            relayOn   <= 1'b0;
            pulseLeft <= pulseLeft - 4'h1;
            if (pulseLeft == 4'h1) begin
              inGap <= 1'b1;
            end
          end else begin
            relayOn <= 1'b1;
          end
        end else begin
          tickCnt <= tickCnt + 5'h01;
        end
      end
    end
  end

endmodule // lcs_alarm_coder

// [lcs_sequencer_properties.sv]
/*
  Port checker for the lubrication cycle sequencer, bound to lcs_sequencer.
  Assumes one clock domain and the synchronous active-low reset.
*/
`timescale 1ns/1ps
module lcs_sequencer_properties #(
  parameter TICK_CYC = 10 // Cycles per tick
) (
  input wire       sys_clk,    // Clock
  input wire       rst_n,      // Reset, low
  input wire       clkEn,      // Clock enable
  input wire       alarmCoded, // Alarm style
  input wire [1:0] stopPolicy, // Stop policy
  input wire       pumpOn,     // Pump drive
  input wire       inLube,     // Lube phase
  input wire       alarmRelay, // Relay energised
  input wire [3:0] alarmCode,  // Active alarm
  input wire       saveStrobe  // Retention pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_strobePulse;
    saveStrobe && clkEn |=> !saveStrobe;
  endproperty
  a_strobePulse: assert property (p_strobePulse)
    else $error("save strobe longer than one cycle");
  property p_strobeOnEnd;
    $fell(inLube) && alarmCode == 4'h0 |-> ##[0:1] saveStrobe;
  endproperty
  a_strobeOnEnd: assert property (p_strobeOnEnd)
    else $error("phase end without save strobe");
  // Pump rests exactly one clock between cycles of one phase
  property p_holdOne;
    clkEn && inLube && $past(inLube) && $fell(pumpOn) && alarmCode == 4'h0
      |=> pumpOn || !inLube;
  endproperty
  a_holdOne: assert property (p_holdOne)
    else $error("pump rest between cycles not one clock");
  property p_stdOn;
    (!alarmCoded && alarmCode != 4'h0) [*4] |-> !alarmRelay;
  endproperty
  a_stdOn: assert property (p_stdOn)
    else $error("relay energised during alarm");
  property p_stdOff;
    (!alarmCoded && alarmCode == 4'h0) [*4] |-> alarmRelay;
  endproperty
  a_stdOff: assert property (p_stdOff)
    else $error("relay dropped without alarm");
  property p_stopAll;
    (stopPolicy == 2'h1 && alarmCode != 4'h0) [*3] |-> !pumpOn;
  endproperty
  a_stopAll: assert property (p_stopAll)
    else $error("pump runs under alarm with stop on all");
  property p_freeze;
    !clkEn |=> $stable(pumpOn) && $stable(inLube) && $stable(alarmCode);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("state moved while disabled");
  property p_codeSet;
    $changed(alarmCode) |-> alarmCode inside {4'h0, 4'h1, 4'h7, 4'h8};
  endproperty
  a_codeSet: assert property (p_codeSet)
    else $error("unknown alarm number");
endmodule // lcs_sequencer_properties

bind lcs_sequencer lcs_sequencer_properties #(.TICK_CYC(TICK_CYC)) u_props (
  .sys_clk, .rst_n, .clkEn, .alarmCoded, .stopPolicy, .pumpOn, .inLube, .alarmRelay,
  .alarmCode, .saveStrobe);

// [lcs_field_model.sv]
/*
  Field side model: cycle sensor, pressure switch, pulse source, level switch.
  Assumes pumpOn from the sequencer and settings from the bench.
*/
`timescale 1ns/1ps
module lcs_field_model (
  input  wire       sys_clk,       // Clock
  input  wire       pumpOn,        // Pump drive
  input  wire       respond,       // Sensors confirm when high
  input  wire [7:0] dly,           // Clocks to confirmation
  input  wire [7:0] pulsePer,      // Pulse period, zero stops
  input  wire       levelLow,      // Reservoir low
  output reg        cycleSensorIn, // Cycle sensor
  output reg        pressureIn,    // Pressure switch
  output reg        pulseIn,       // External pulse
  output reg        lowLevelIn     // Level switch
);
  reg [7:0] runCnt = 8'h0;
  reg [7:0] perCnt = 8'h0;
  initial begin
    cycleSensorIn = 1'b0;
    pressureIn = 1'b0;
    pulseIn = 1'b0;
    lowLevelIn = 1'b0;
  end
  // Pressure builds after a delay and vents as soon as the pump stops
  always @(posedge sys_clk) begin
    runCnt <= !pumpOn ? 8'h0 : (runCnt == 8'hFF) ? runCnt : runCnt + 8'h1;
    cycleSensorIn <= respond && pumpOn && (runCnt >= dly);
    pressureIn <= respond && pumpOn && (runCnt >= dly);
    lowLevelIn <= levelLow;
  end
  // Two-clock pulses, wide enough to survive the input synchroniser
  always @(posedge sys_clk) begin
    perCnt <= (perCnt + 8'h1 >= pulsePer) ? 8'h0 : perCnt + 8'h1;
    pulseIn <= (pulsePer != 8'h0) && (perCnt < 8'h2);
  end
endmodule // lcs_field_model

// [testbench.sv]
/*
  Self-checking bench for lcs_sequencer with the field model.
  Assumes TICK_CYC of 10, so one second of settings is 100 clocks.
*/
`timescale 1ns/1ps
`include "lcs_defines.vh"
module testbench;
  reg sys_clk = 1'b0, rst_n = 1'b0, clkEn = 1'b1, cycleEnd, alarmCoded, alarmClear, keptLube;
  reg [1:0] cycleMonitor, standby_source_select, powerOnMode, stopPolicy;
  reg [19:0] standbySec;
  reg [15:0] pauseCount, cycleCount;
  reg [7:0] cycleToutSec, lubeSec, lubeCycles, prelubeCount, keptCycles, dly, pulsePer;
  reg respond, levelLow;
  wire cycleSensorIn, pressureIn, pulseIn, lowLevelIn, pumpOn, inLube, alarmRelay, saveStrobe;
  wire [3:0] alarmCode;
  wire [7:0] saveCycles;
  int err_count = 0, checks_done = 0, strobes = 0;

  lcs_sequencer #(.TICK_CYC(10)) u_dut (
    .sys_clk, .rst_n, .clkEn, .cycleEnd, .cycleMonitor, .standby_source_select, .standbySec,
    .cycleToutSec, .lubeSec, .lubeCycles, .pauseCount, .cycleCount, .powerOnMode,
    .prelubeCount, .alarmCoded, .stopPolicy, .alarmClear, .keptLube, .keptCycles,
    .cycleSensorIn, .pressureIn, .pulseIn, .lowLevelIn, .pumpOn, .inLube, .alarmRelay,
    .alarmCode, .saveStrobe, .saveCycles);
  lcs_field_model u_field (.sys_clk, .pumpOn, .respond, .dly, .pulsePer, .levelLow,
    .cycleSensorIn, .pressureIn, .pulseIn, .lowLevelIn);

  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (saveStrobe === 1'b1) strobes <= strobes + 1;

  task test_done;
    if (err_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [19:0] got, input logic [19:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  function logic near(input int n, input int e, input int t);
    near = (n >= e - t) && (n <= e + t);
  endfunction
  task tk(input int c);
    repeat (c) @(negedge sys_clk);
  endtask
  // Bounded wait on pump, phase or alarm; n is the clocks spent
  task waitSig(input int s, input logic v, input int lim, output int n);
    n = 0;
    while ((s == 0 ? pumpOn : s == 1 ? inLube : (alarmCode != 4'h0)) !== v && n < lim) begin
      tk(1);
      n = n + 1;
    end
  endtask
  task cfg;
    cycleEnd = `LCS_END_CYCLE;
    cycleMonitor = `LCS_MON_TIMER;
    standby_source_select = `LCS_SBY_TIMER;
    standbySec = 20'h5;
    cycleToutSec = `LCS_DEF_TOUT_S;
    {lubeSec, lubeCycles, prelubeCount, keptCycles} = {8'h2, 8'h1, 8'h0, 8'h1};
    {pauseCount, cycleCount} = {16'h4, 16'h3};
    powerOnMode = `LCS_PON_LUBE;
    stopPolicy = `LCS_STOP_NONE;
    {alarmCoded, alarmClear, keptLube, respond, levelLow} = 5'h02;
    {dly, pulsePer} = {8'h14, 8'h0};
  endtask
  task boot;
    rst_n = 1'b0;
    tk(20);
    rst_n = 1'b1;
  endtask

  initial begin
    #2000000;
    err_count = err_count + 1;
    test_done();
  end

  initial begin
    int n, k, r, sb, ls, p, s0, hi;
    logic prev;
    k = $urandom(96);
    cfg();
    // Power-on phase per mode, reset levels, a frozen start
    for (k = 0; k < 3; k++) begin
      cfg();
      powerOnMode = k[1:0];
      keptLube = $urandom % 2;
      rst_n = 1'b0;
      tk(20);
      chk({pumpOn, inLube, alarmRelay, alarmCode}, 20'h10);
      rst_n = 1'b1;
      clkEn = 1'b0;
      tk(5);
      clkEn = 1'b1;
      tk(10);
      chk(inLube, k == 1 || (k == 2 && keptLube));
    end
    // Timed run, two cycles a phase, timed standby
    cfg();
    ls = 2 + $urandom % 2;
    sb = 5 + $urandom % 3;
    {lubeSec, standbySec, lubeCycles} = {ls[7:0], sb[19:0], 8'h2};
    s0 = strobes;
    boot();
    waitSig(0, 1, 20, n);
    chk(inLube, 1);
    waitSig(0, 0, 500, n);
    chk(near(n, ls * 100, 100), 1);
    waitSig(0, 1, 20, n);
    chk(near(n, 2, 2), 1);
    waitSig(0, 0, 500, n);
    waitSig(1, 0, 5, n);
    chk(inLube, 0);
    waitSig(0, 1, 1000, n);
    chk(near(n, sb * 100, 110), 1);
    chk(strobes != s0, 1);
    // Prelube runs ended by the sensors, then a quiet standby
    cfg();
    {cycleMonitor, prelubeCount, powerOnMode} = {`LCS_MON_PS, 8'h2, `LCS_PON_STANDBY};
    boot();
    for (k = 0; k < 2; k++) begin
      waitSig(0, 1, 60, n);
      waitSig(0, 0, 100, n);
      chk(near(n, 25, 10), 1);
    end
    waitSig(0, 1, 200, n);
    chk(n, 200);
    // Silent switch: timeout alarm, stop, standard then coded relay
    cfg();
    {cycleMonitor, cycleToutSec, stopPolicy, respond} = {`LCS_MON_PS, 8'h1, `LCS_STOP_ALL, 1'b0};
    {powerOnMode, keptLube} = {`LCS_PON_RESUME, 1'b1};
    boot();
    waitSig(2, 1, 300, n);
    chk(alarmCode, `LCS_ALARM_PRESS);
    chk(saveCycles, keptCycles);
    tk(5);
    chk({pumpOn, alarmRelay}, 0);
    alarmCoded = 1'b1;
    // Find the long gap first: a burst pause is shorter than 60 clocks
    n = 0;
    while (n < 60) begin
      tk(1);
      n = (alarmRelay === 1'b0) ? n + 1 : 0;
    end
    r = 0;
    hi = 0;
    prev = alarmRelay;
    repeat (850) begin
      tk(1);
      if (alarmRelay === 1'b1 && prev === 1'b0) r = r + 1;
      if (alarmRelay === 1'b1) hi = hi + 1;
      prev = alarmRelay;
    end
    chk(r, `LCS_ALARM_PRESS);
    chk(hi, `LCS_ALARM_PRESS * `LCS_BURST_TICKS * 10);
    alarmCoded = 1'b0;
    tk(20);
    chk(alarmRelay, 0);
    alarmClear = 1'b1;
    tk(5);
    alarmClear = 1'b0;
    tk(10);
    chk({alarmCode, alarmRelay}, 20'h1);
    // Timeout with no stop policy: alarm shown, lubrication carries on
    cfg();
    {cycleMonitor, cycleToutSec, respond, lubeCycles} = {`LCS_MON_PS, 8'h1, 1'b0, 8'h2};
    boot();
    waitSig(2, 1, 300, n);
    waitSig(0, 1, 20, n);
    chk({alarmCode, inLube, pumpOn}, {`LCS_ALARM_PRESS, 2'h3});
    // Pulse mode: both phases follow the external pulse count
    cfg();
    p = 20 + $urandom % 10;
    {cycleEnd, cycleMonitor, powerOnMode} = {`LCS_END_PULSE, `LCS_MON_NONE, `LCS_PON_STANDBY};
    pulsePer = p[7:0];
    boot();
    waitSig(0, 1, 400, n);
    chk(n <= 5 * p + 10, 1);
    waitSig(0, 0, 400, n);
    chk(near(n, 3 * p, p + 5), 1);
    // Counter standby with no pulses runs into its time limit
    cfg();
    {standby_source_select, pauseCount, powerOnMode} = {`LCS_SBY_TOUT, 16'h64, `LCS_PON_STANDBY};
    boot();
    waitSig(2, 1, 700, n);
    chk(alarmCode, `LCS_ALARM_PAUSE);
    // Low level under every stop policy
    for (k = 0; k < 4; k++) begin
      cfg();
      {stopPolicy, lubeSec, levelLow} = {k[1:0], 8'h5, 1'b1};
      boot();
      tk(60);
      chk({alarmCode, pumpOn}, {`LCS_ALARM_LEVEL, !(k == 1 || k == 3)});
    end
    test_done();
  end
endmodule // testbench
